/* core/gxp_pair_read.v */
`timescale 1ns/100ps
`default_nettype none
`include "gxp_defines.vh"

module gxp_pair_read #(
  parameter [6:0] DEV_ADDR = 7'h20,        // bus address, arbitrary default
  parameter       PINS     = 16            // number of port pins
) (
  input  wire                  mclk,           // system clock, 10 MHz
  input  wire                  sys_rst,        // synchronous reset, active high
  input  wire                  scl_i,          // bus clock pin level
  input  wire                  sda_i,          // bus data pin level
  output reg                   sda_o_r,        // bus data drive value, always low
  output reg                   sda_oe_r,       // bus data pulled low while high
  output reg  [7:0]            rd_addr_r,      // register fetched from the map
  output reg                   rd_stb_r,       // fetch in progress, data valid on reg_rd_data
  input  wire [7:0]            reg_rd_data,    // contents of register rd_addr_r
  output reg                   int_clr0_r,     // pulse: input port 0 was read
  output reg                   int_clr1_r,     // pulse: input port 1 was read
  input  wire [PINS-1:0]       pin_dir,        // 1 = pin is an input
  input  wire [PINS-1:0]       pin_out,        // output data per pin
  input  wire [2*PINS-1:0]     pin_drv,        // two-bit strength code per pin
  output reg  [4*PINS-1:0]     pad_hi_en_r,    // fingers pulling the pad high
  output reg  [4*PINS-1:0]     pad_lo_en_r,    // fingers pulling the pad low
  output reg  [7:0]            ptr_r           // current register pointer
);

  // bus state machine codes
  localparam [3:0] ST_IDLE  = 4'h0;        // bus free or not addressed
  localparam [3:0] ST_ADDR  = 4'h1;        // taking the address byte
  localparam [3:0] ST_AACK  = 4'h2;        // acknowledging the address
  localparam [3:0] ST_CMD   = 4'h3;        // taking the command byte
  localparam [3:0] ST_CACK  = 4'h4;        // acknowledging the command
  localparam [3:0] ST_WDAT  = 4'h5;        // write data, taken and dropped
  localparam [3:0] ST_WACK  = 4'h6;        // acknowledging write data
  localparam [3:0] ST_RLOAD = 4'h7;        // waiting for the fetched byte
  localparam [3:0] ST_RDAT  = 4'h8;        // shifting a byte out
  localparam [3:0] ST_RACK  = 4'h9;        // master's ack bit

  // pin synchronisers; stage 1 feeds only stage 2
  reg        scl_s1_r;                     // first stage, clock pin
  reg        scl_s2_r;                     // second stage, clock pin
  reg        scl_d_r;                      // delayed copy for edges
  reg        sda_s1_r;                     // first stage, data pin
  reg        sda_s2_r;                     // second stage, data pin
  reg        sda_d_r;                      // delayed copy for edges
  wire       scl_rise;                     // bus clock rose
  wire       scl_fall;                     // bus clock fell
  wire       start_det;                    // start or repeated start
  wire       stop_det;                     // stop condition

  reg  [3:0] state_r;                      // bus state
  reg  [3:0] bit_cnt_r;                    // bits moved in this byte
  reg  [7:0] rx_r;                         // receive shifter
  reg  [7:0] tx_r;                         // transmit shifter
  reg        rw_r;                         // read bit of last address
  reg        mack_r;                       // master acknowledged
  reg  [7:0] cur_reg_r;                    // register of byte in flight
  wire       cap;                          // capture point for next byte
  wire       buf_in_rdy;                   // buffer has room
  wire       buf_out_v;                    // fetched byte waiting
  wire [7:0] buf_out_d;                    // fetched byte
  wire       pop;                          // shifter takes the byte
  wire       flush;                        // drop stale fetches
  wire [4*PINS-1:0] pad_hi_nxt;            // next pull-up finger enables
  wire [4*PINS-1:0] pad_lo_nxt;            // next pull-down finger enables

  // two flops per pin, then one more for edge detection
  always @(posedge mclk) begin
    if (sys_rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  assign scl_rise  = scl_s2_r & ~scl_d_r;
  assign scl_fall  = ~scl_s2_r & scl_d_r;
  // data moving while clock stays high marks start or stop
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // the next byte is captured as the ack clock pulse falls
  assign cap   = scl_fall & (((state_r == ST_AACK) & rw_r) | ((state_r == ST_RACK) & mack_r));
  assign pop   = (state_r == ST_RLOAD) & buf_out_v;
  assign flush = start_det | stop_det;

  // byte fetch into the buffer; a full buffer holds the strobe
  always @(posedge mclk) begin
    if (sys_rst || flush) begin
      rd_stb_r  <= 1'b0;
      rd_addr_r <= `GXP_PTR_RST;
    end else if (cap) begin
      rd_stb_r  <= 1'b1;
      rd_addr_r <= ptr_r;
    end else if (rd_stb_r && buf_in_rdy) begin
      rd_stb_r  <= 1'b0;
    end
  end

  // absorbs the gap between fetch and shift-out so no byte is lost
  gxp_fifo2 #(
    .W         (8)
  ) u_buf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (rd_stb_r),
    .in_ready  (buf_in_rdy),
    .in_data   (reg_rd_data),
    .out_valid (buf_out_v),
    .out_ready (pop),
    .out_data  (buf_out_d)
  );

  // bus state machine; start and stop override every state
  always @(posedge mclk) begin
    int_clr0_r <= 1'b0;
    int_clr1_r <= 1'b0;
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      rx_r       <= 8'h00;
      tx_r       <= 8'h00;
      rw_r       <= 1'b0;
      mack_r     <= 1'b0;
      cur_reg_r  <= `GXP_PTR_RST;
      ptr_r      <= `GXP_PTR_RST;
      sda_o_r    <= 1'b0;
      sda_oe_r   <= 1'b0;
      int_clr0_r <= 1'b0;
      int_clr1_r <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps the pointer as left by the last read
      state_r   <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end else if (stop_det) begin
      state_r   <= ST_IDLE;
      sda_oe_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDAT: begin
          if (scl_rise) begin
            rx_r      <= {rx_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == `GXP_BYTE_BITS) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              if (rx_r[7:1] == DEV_ADDR) begin
                rw_r     <= rx_r[`GXP_RW_BIT];
                sda_oe_r <= 1'b1;
                state_r  <= ST_AACK;
              end else begin
                state_r  <= ST_IDLE;        // another device's address
              end
            end else if (state_r == ST_CMD) begin
              ptr_r    <= rx_r;
              sda_oe_r <= 1'b1;
              state_r  <= ST_CACK;
            end else begin
              sda_oe_r <= 1'b1;             // write data is acked and dropped
              state_r  <= ST_WACK;
            end
          end
        end
        ST_AACK, ST_CACK, ST_WACK: begin
          if (scl_fall) begin
            sda_oe_r  <= 1'b0;
            bit_cnt_r <= 4'h0;
            if (state_r == ST_AACK && rw_r) begin
              cur_reg_r <= ptr_r;
              ptr_r[`GXP_PAIR_BIT] <= ~ptr_r[`GXP_PAIR_BIT];
              state_r   <= ST_RLOAD;
            end else if (state_r == ST_AACK) begin
              state_r   <= ST_CMD;
            end else begin
              state_r   <= ST_WDAT;
            end
          end
        end
        ST_RLOAD: begin
          if (pop) begin
            // open drain: enable pulls low for a zero bit
            tx_r      <= {buf_out_d[6:0], 1'b0};
            sda_oe_r  <= ~buf_out_d[7];
            bit_cnt_r <= 4'h1;
            state_r   <= ST_RDAT;
          end
        end
        ST_RDAT: begin
          if (scl_fall) begin
            if (bit_cnt_r == `GXP_BYTE_BITS) begin
              sda_oe_r <= 1'b0;             // release for master's ack
              state_r  <= ST_RACK;
            end else begin
              sda_oe_r  <= ~tx_r[7];
              tx_r      <= {tx_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s2_r;
            // interrupt clear follows the rising edge of the ack or nack pulse
            int_clr0_r <= (cur_reg_r == `GXP_REG_IN_PORT0);
            int_clr1_r <= (cur_reg_r == `GXP_REG_IN_PORT1);
          end else if (scl_fall) begin
            if (mack_r) begin
              // every register has a partner, so alternation is uniform
              cur_reg_r <= ptr_r;
              ptr_r[`GXP_PAIR_BIT] <= ~ptr_r[`GXP_PAIR_BIT];
              state_r   <= ST_RLOAD;
            end else begin
              state_r   <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // pad finger enables per pin, registered so pads never see decode glitches
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pad
      reg [3:0] fmask;                     // fingers chosen by the strength code
      always @* begin
        case (pin_drv[2*gi +: 2])
          `GXP_DRV_CODE_00: fmask = `GXP_FMASK_00;
          `GXP_DRV_CODE_01: fmask = `GXP_FMASK_01;
          `GXP_DRV_CODE_10: fmask = `GXP_FMASK_10;
          `GXP_DRV_CODE_11: fmask = `GXP_FMASK_11;
          default:          fmask = `GXP_FMASK_11;
        endcase
      end
      // input pins float; outputs drive one side with the chosen fingers
      assign pad_hi_nxt[4*gi +: 4] = (~pin_dir[gi] & pin_out[gi]) ? fmask : 4'h0;
      assign pad_lo_nxt[4*gi +: 4] = (~pin_dir[gi] & ~pin_out[gi]) ? fmask : 4'h0;
    end
  endgenerate

  // one register stage for all pads; a single process keeps one driver per output
  always @(posedge mclk) begin
    if (sys_rst) begin
      pad_hi_en_r <= {4*PINS{1'b0}};
      pad_lo_en_r <= {4*PINS{1'b0}};
    end else begin
      pad_hi_en_r <= pad_hi_nxt;
      pad_lo_en_r <= pad_lo_nxt;
    end
  end

endmodule // gxp_pair_read

`default_nettype wire

/* include/gxp_defines.vh */
`ifndef GXP_DEFINES_VH
`define GXP_DEFINES_VH

// register pointer values of the two input port registers
`define GXP_REG_IN_PORT0   8'h00
`define GXP_REG_IN_PORT1   8'h01
// pointer value after reset
`define GXP_PTR_RST        8'h00
// pair partner is found by flipping this bit of the pointer
`define GXP_PAIR_BIT       0
// read/write bit position within the address byte
`define GXP_RW_BIT         0
// bits in one bus byte
`define GXP_BYTE_BITS      4'h8

// drive strength codes, two bits per pin
`define GXP_DRV_W          2
`define GXP_DRV_CODE_00    2'h0
`define GXP_DRV_CODE_01    2'h1
`define GXP_DRV_CODE_10    2'h2
`define GXP_DRV_CODE_11    2'h3
// finger enable masks, four fingers per pin
`define GXP_FINGERS        4
`define GXP_FMASK_00       4'h1
`define GXP_FMASK_01       4'h7
`define GXP_FMASK_10       4'h3
`define GXP_FMASK_11       4'hf

`endif

/* core/gxp_fifo2.v */
`timescale 1ns/100ps
`default_nettype none

// two-entry buffer; the filling side sees in_ready low while both slots hold data
module gxp_fifo2 #(
  parameter W = 8                          // data width
) (
  input  wire         mclk,                // system clock
  input  wire         sys_rst,             // synchronous reset, active high
  input  wire         flush,               // drop all held entries
  input  wire         in_valid,            // filling side offers a word
  output wire         in_ready,            // room for a word
  input  wire [W-1:0] in_data,             // word offered
  output wire         out_valid,           // a word is held
  input  wire         out_ready,           // draining side takes the word
  output wire [W-1:0] out_data             // oldest word, straight from a slot
);

  reg  [W-1:0] slot_r [0:1];               // the two storage slots
  reg          wr_ptr_r;                   // slot written next
  reg          rd_ptr_r;                   // slot read next
  reg  [1:0]   cnt_r;                      // number of words held
  wire         push;                       // word accepted
  wire         pop;                        // word removed

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = slot_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and occupancy bookkeeping; flush wins over any transfer
  always @(posedge mclk) begin
    if (sys_rst || flush) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage needs no reset; occupancy guards it
  always @(posedge mclk) begin
    if (push) begin
      slot_r[wr_ptr_r] <= in_data;
    end
  end

endmodule // gxp_fifo2

`default_nettype wire

/* tb/gxp_i2c_master.sv */
`timescale 1ns/100ps
`default_nettype none
// bus master model: scl low 500 ns and high 300 ns, 800 ns a bit
module gxp_i2c_master (
  input  wire logic mclk,   // paces the model
  input  wire logic sda,    // wired data line
  output var  logic scl,    // bus clock, high outside frames
  output var  logic sda_m   // 1 = released to pull-up
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // step n edges, then off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // a = 1: start or restart; a = 0: stop, scl left high
  task automatic cond(input logic a);
    sda_m = a;
    tick(4);
    scl = 1'b1;
    tick(3);
    sda_m = ~a;
    tick(3);
    if (a) scl = 1'b0;
    tick(1);
  endtask
  // one bit; sda is only moved while scl is low
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    tick(4);
    scl = 1'b1;
    tick(3);
    r = sda;
    scl = 0;
    tick(1);
  endtask
  // nine bits msb first; pre stretches the low phase so a prefetch can land
  task automatic xfer(input logic [8:0] d, input int pre, output logic [8:0] q);
    tick(pre);
    for (int i = 8; i >= 0; i--) bitx(d[i], q[i]);
  endtask
endmodule // gxp_i2c_master
`default_nettype wire

/* tb/gxp_pair_read_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gxp_defines.vh"
// port-level watch on the pair-read block
module gxp_pair_read_checker #(
  parameter PINS = 16                 // port pins
) (
  input wire logic              mclk,        // clock
  input wire logic              sys_rst,     // reset
  input wire logic              scl_i,       // bus clock
  input wire logic              sda_oe_r,    // data pull
  input wire logic [7:0]        rd_addr_r,   // fetch address
  input wire logic              rd_stb_r,    // fetch
  input wire logic              int_clr0_r,  // port 0 read
  input wire logic              int_clr1_r,  // port 1 read
  input wire logic [PINS-1:0]   pin_dir,     // 1 = input
  input wire logic [PINS-1:0]   pin_out,     // out data
  input wire logic [2*PINS-1:0] pin_drv,     // strengths
  input wire logic [4*PINS-1:0] pad_hi_en_r, // up fingers
  input wire logic [4*PINS-1:0] pad_lo_en_r, // down fingers
  input wire logic [7:0]        ptr_r        // pointer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // finger mask of a strength code
  function automatic logic [3:0] fm(input logic [1:0] c);
    fm = (c == 2'h0) ? `GXP_FMASK_00 : (c == 2'h1) ? `GXP_FMASK_01 : (c == 2'h2) ? `GXP_FMASK_10 : `GXP_FMASK_11;
  endfunction
  a_rst_idle: assert property ($fell(sys_rst) |-> ptr_r == 8'h00 && !sda_oe_r && !rd_stb_r)
    else $error("not idle after reset");
  a_ptr_toggle: assert property ($rose(rd_stb_r) |-> ##[0:1] ptr_r == (rd_addr_r ^ 8'h01))
    else $error("pointer not at pair partner");
  a_fetch_short: assert property (rd_stb_r |=> ##[0:1] !rd_stb_r)
    else $error("fetch too long");
  a_fetch_hold: assert property (rd_stb_r && $past(rd_stb_r) |-> $stable(rd_addr_r))
    else $error("fetch address moved");
  a_fetch_scl_low: assert property ($rose(rd_stb_r) |-> !scl_i)
    else $error("fetch not after ack clock fall");
  // data may only move while the clock is low
  a_oe_scl_low: assert property ($changed(sda_oe_r) |-> !scl_i)
    else $error("data moved with clock high");
  a_clr0_port: assert property (int_clr0_r |-> ptr_r == 8'h01 && !int_clr1_r)
    else $error("port 0 clear without port 0 read");
  a_clr1_port: assert property (int_clr1_r |-> ptr_r == 8'h00)
    else $error("port 1 clear without port 1 read");
  a_clr_pulse: assert property (int_clr0_r || int_clr1_r |=> !int_clr0_r && !int_clr1_r)
    else $error("clear pulse too long");
  for (genvar i = 0; i < PINS; i++) begin : g_pad
    a_pad_drive: assert property (!$past(sys_rst) |-> pad_hi_en_r[4*i+:4] ==
      ($past(!pin_dir[i] && pin_out[i]) ? fm($past(pin_drv[2*i+:2])) : 4'h0)) else $error("up fingers wrong");
    a_pad_sink: assert property (!$past(sys_rst) |-> pad_lo_en_r[4*i+:4] ==
      ($past(!pin_dir[i] && !pin_out[i]) ? fm($past(pin_drv[2*i+:2])) : 4'h0)) else $error("down fingers wrong");
  end
  c_fetch: cover property ($rose(rd_stb_r));
  c_clr0: cover property (int_clr0_r);
  c_clr1: cover property (int_clr1_r);
endmodule // gxp_pair_read_checker
bind gxp_pair_read gxp_pair_read_checker #(.PINS(PINS)) i_chk (.mclk(mclk), .sys_rst(sys_rst), .scl_i(scl_i),
  .sda_oe_r(sda_oe_r), .rd_addr_r(rd_addr_r), .rd_stb_r(rd_stb_r), .int_clr0_r(int_clr0_r),
  .int_clr1_r(int_clr1_r), .pin_dir(pin_dir), .pin_out(pin_out), .pin_drv(pin_drv),
  .pad_hi_en_r(pad_hi_en_r), .pad_lo_en_r(pad_lo_en_r), .ptr_r(ptr_r));
`default_nettype wire

/* tb/tb_gxp_pair_read.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_gxp_pair_read;
  logic              mclk;                 // 10 MHz
  logic              sys_rst;              // reset
  logic [15:0]       pin_dir;              // 1 = input
  logic [15:0]       pin_out;              // out data
  logic [31:0]       pin_drv;              // strengths
  logic [8:0]        q;                    // bits seen by master
  wire  logic        scl, sda_m, sda_oe, rd_stb, clr0, clr1;
  wire  logic [7:0]  rd_addr, ptr;
  wire  logic [63:0] pad_hi, pad_lo;
  wire  logic        sda;                  // open drain with pull-up
  wire  logic        sda_o;                // device's drive value
  wire  logic [7:0]  rd_data;              // map model, pattern per address
  int                err_count = 0;
  int                tests_run = 0;
  int                clr0_n = 0;
  int                clr1_n = 0;
  assign sda     = sda_m & ~sda_oe;
  assign rd_data = rd_addr ^ 8'h5a;
  gxp_i2c_master i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  gxp_pair_read i_dut (.mclk(mclk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o_r(sda_o), .sda_oe_r(sda_oe),
    .rd_addr_r(rd_addr), .rd_stb_r(rd_stb), .reg_rd_data(rd_data), .int_clr0_r(clr0), .int_clr1_r(clr1),
    .pin_dir(pin_dir), .pin_out(pin_out), .pin_drv(pin_drv), .pad_hi_en_r(pad_hi), .pad_lo_en_r(pad_lo), .ptr_r(ptr));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // count interrupt clear pulses
  always @(posedge mclk) begin
    clr0_n <= clr0_n + int'(clr0);
    clr1_n <= clr1_n + int'(clr1);
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // start, write address, command; frame left open for a restart
  task automatic wr_cmd(input logic [7:0] c);
    i_mst.cond(1'b1);
    i_mst.xfer({8'h40, 1'b1}, 0, q);
    chk("address ack", 1'b0, q[0]);
    i_mst.xfer({c, 1'b1}, 0, q);
    chk("command ack", 1'b0, q[0]);
    chk("pointer", c, ptr);
  endtask
  // (re)start, read address, n bytes from the pair starting at a, nack on the last
  task automatic rd(input int n, input logic [7:0] a);
    i_mst.cond(1'b1);
    i_mst.xfer({8'h41, 1'b1}, 0, q);
    chk("read address ack", 1'b0, q[0]);
    for (int k = 0; k < n; k++) begin
      i_mst.xfer({8'hff, k == n - 1}, 4, q);
      chk("read byte", a ^ k[0] ^ 8'h5a, q[8:1]);
    end
  endtask
  task automatic test_reset();
    chk("pointer at reset", 8'h00, ptr);
    chk("data pull at reset", 1'b0, sda_oe);
    chk("data drive value", 1'b0, sda_o);
    wr_cmd(8'h03);
    i_mst.cond(1'b0);
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("pointer after reset", 8'h00, ptr);
    $display("test_reset done");
  endtask
  task automatic test_badaddr();
    i_mst.cond(1'b1);
    i_mst.xfer({8'h42, 1'b1}, 0, q);
    chk("foreign address ack", 1'b1, q[0]);
    i_mst.cond(1'b0);
    // write data after a command is acked and leaves the pointer alone
    wr_cmd(8'h06);
    i_mst.xfer({8'h99, 1'b1}, 0, q);
    chk("write data ack", 1'b0, q[0]);
    chk("pointer after write data", 8'h06, ptr);
    i_mst.cond(1'b0);
    $display("test_badaddr done");
  endtask
  // eight starts over four pairs, three bytes each; ports 0 and 1 give clear pulses
  task automatic test_pairs();
    for (int c = 0; c < 8; c++) begin
      wr_cmd(8'(c));
      rd(3, 8'(c));
      i_mst.cond(1'b0);
      chk("pointer after read", 8'(c) ^ 8'h01, ptr);
    end
    chk("port 0 clears", 3, clr0_n);
    chk("port 1 clears", 3, clr1_n);
    $display("test_pairs done");
  endtask
  task automatic test_restart();
    wr_cmd(8'h05);
    rd(1, 8'h05);
    rd(2, 8'h04);
    i_mst.cond(1'b0);
    $display("test_restart done");
  endtask
  task automatic test_long();
    wr_cmd(8'h02);
    rd(20, 8'h02);
    i_mst.cond(1'b0);
    chk("pointer after long read", 8'h02, ptr);
    $display("test_long done");
  endtask
  // every code on every pin, high and low, upper pins as inputs
  task automatic test_pads();
    logic [3:0]  fm [4] = '{4'h1, 4'h7, 4'h3, 4'hf};  // 10b gives two fingers
    logic [31:0] d;
    logic [63:0] eh, el;
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 16; i++) d[2*i+:2] = 2'(c + i);
      @(posedge mclk);
      #1 pin_drv = d;
      pin_dir = 16'hf000;
      pin_out = c[2] ? 16'haaaa : 16'h5555;
      repeat (2) @(posedge mclk);
      #1;
      for (int i = 0; i < 16; i++) begin
        eh[4*i+:4] = (!pin_dir[i] && pin_out[i]) ? fm[2'(c + i)] : 4'h0;
        el[4*i+:4] = (!pin_dir[i] && !pin_out[i]) ? fm[2'(c + i)] : 4'h0;
      end
      chk("up fingers", eh, pad_hi);
      chk("down fingers", el, pad_lo);
    end
    $display("test_pads done");
  endtask
  initial begin
    repeat (80000) @(posedge mclk);
    err_count++;
    $display("Error run time: expected end, seen none");
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    pin_dir = 16'hffff;
    pin_out = 16'h0000;
    pin_drv = 32'h0;
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1 test_reset();
    test_pairs();
    test_badaddr();
    test_restart();
    test_long();
    test_pads();
    print_verdict();
  end
endmodule // tb_gxp_pair_read
`default_nettype wire
